/* rtl/crcecs_pkg.sv */
// Constants and types shared by the CRC engine control and status block
package crcecs_pkg;

    // ****************************************
    // Register bus geometry and addresses
    // ****************************************
    localparam int unsigned ADDR_W = 2;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned CNT_W  = 5;
    localparam int unsigned PTR_W  = 4;
    localparam int unsigned POLYNOMIAL_LENGTH_W = 4;
    localparam int unsigned INT_W  = 1;

    localparam logic [ADDR_W-1:0] ADDR_CTRL      = 2'h0;
    localparam logic [ADDR_W-1:0] ADDR_INT_STAT  = 2'h1;
    localparam logic [ADDR_W-1:0] ADDR_INT_MASK  = 2'h2;

    // ****************************************
    // Control and status field positions
    // ****************************************
    localparam int unsigned BIT_EN    = 15;
    localparam int unsigned BIT_RSVD  = 14;
    localparam int unsigned BIT_IDLE  = 13;
    localparam int unsigned CNT_HI    = 12;
    localparam int unsigned CNT_LO    = 8;
    localparam int unsigned BIT_FULL  = 7;
    localparam int unsigned BIT_EMPTY = 6;
    localparam int unsigned BIT_ISEL  = 5;
    localparam int unsigned BIT_GO    = 4;
    localparam int unsigned BIT_DIR   = 3;
    localparam int unsigned INT_CRC   = 0;

    // ****************************************
    // Capacity and word length by polynomial length
    // ****************************************
    localparam logic [POLYNOMIAL_LENGTH_W-1:0] POLYNOMIAL_LENGTH_SHORT_MAX = 4'h7;
    localparam logic [CNT_W-1:0]  DEPTH_SHORT    = 5'h10;
    localparam logic [CNT_W-1:0]  DEPTH_LONG     = 5'h08;
    localparam logic [CNT_W-1:0]  BITS_SHORT     = 5'h08;
    localparam logic [CNT_W-1:0]  BITS_LONG      = 5'h10;
    localparam logic [CNT_W-1:0]  CNT_ONE        = 5'h01;
    localparam logic [CNT_W-1:0]  CNT_ZERO       = 5'h00;
    localparam logic [PTR_W-1:0]  PTR_ONE        = 4'h1;
    localparam int unsigned       SHORT_SHIFT    = 8;

    // Shifter states
    typedef enum logic [0:0] {
        CRCECS_IDLE  = 1'b0,
        CRCECS_SHIFT = 1'b1
    } crcecs_state_t;

endpackage

/* rtl/crcecs_top.sv */
// Control, status, input FIFO and serial shifter of the CRC engine
//
// Added by the designer: the placing of the registers and strobed register access.
`timescale 1ns/100ps

module crcecs_top
    import crcecs_pkg::*;
#(
    parameter int unsigned DEPTH = 16
) (
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              sys_rst_i,
    // Register port
    input  wire logic [ADDR_W-1:0] reg_addr_i,
    input  wire logic [DATA_W-1:0] reg_wdata_i,
    input  wire logic              reg_wr_i,
    input  wire logic              reg_rd_i,
    output logic      [DATA_W-1:0] reg_rdata_o,
    // Device context
    input  wire logic [POLYNOMIAL_LENGTH_W-1:0] polynomial_length_i,
    input  wire logic              idle_mode_i,
    // Words from the input data register
    input  wire logic              push_valid_i,
    input  wire logic [DATA_W-1:0] push_data_i,
    output logic                   push_ready_o,
    // Bit stream to the CRC datapath
    output logic                   crc_bit_o,
    output logic                   crc_bit_valid_o,
    output logic                   result_ready_o,
    output logic                   crc_state_clear_o,
    // Interrupt
    output logic                   irq_o
);

    // ****************************************
    // Helpers
    // ****************************************
    // Capacity follows the polynomial length
    function automatic logic [CNT_W-1:0] fifo_cap(input logic [POLYNOMIAL_LENGTH_W-1:0] polynomial_length);
        fifo_cap = (polynomial_length <= POLYNOMIAL_LENGTH_SHORT_MAX) ? DEPTH_SHORT : DEPTH_LONG;
    endfunction

    function automatic logic short_word(input logic [POLYNOMIAL_LENGTH_W-1:0] polynomial_length);
        short_word = (polynomial_length <= POLYNOMIAL_LENGTH_SHORT_MAX);
    endfunction

    // ****************************************
    // State
    // ****************************************
    logic                 en_ff, nxt_en;
    logic                 idle_stop_ff, nxt_idle_stop;
    logic                 isel_ff, nxt_isel;
    logic                 go_ff, nxt_go;
    logic                 dir_ff, nxt_dir;
    logic [INT_W-1:0]     stat_ff, nxt_stat;
    logic [INT_W-1:0]     mask_ff, nxt_mask;
    logic [DATA_W-1:0]    rdata_ff, nxt_rdata;
    logic                 irq_ff, nxt_irq;
    logic                 clear_ff, nxt_clear;

    logic [DATA_W-1:0]    mem_ff [DEPTH];
    logic [PTR_W-1:0]     wr_ptr_ff, nxt_wr_ptr;
    logic [PTR_W-1:0]     rd_ptr_ff, nxt_rd_ptr;
    logic [CNT_W-1:0]     count_ff, nxt_count;
    logic                 ready_ff, nxt_ready;
    crcecs_state_t        state_ff, nxt_state;
    logic [DATA_W-1:0]    shreg_ff, nxt_shreg;
    logic [CNT_W-1:0]     bits_ff, nxt_bits;
    logic                 lsb_ff, nxt_lsb;
    logic                 bit_ff, nxt_bit;
    logic                 bit_vld_ff, nxt_bit_vld;
    logic                 done_ff, nxt_done;

    logic                 idle_meta_ff;
    logic                 idle_ff;

    logic                 push_acc;
    logic                 pop;
    logic                 halt;
    logic                 empty_evt;
    logic                 done_evt;
    logic                 full_flag;
    logic                 empty_flag;

    // ****************************************
    // Idle request synchroniser
    // ****************************************
    // Idle comes from the power controller, so it is re-timed before use
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            idle_meta_ff <= 1'b0;
            idle_ff      <= 1'b0;
        end else begin
            idle_meta_ff <= idle_mode_i;
            idle_ff      <= idle_meta_ff;
        end
    end

    // ****************************************
    // FIFO and serial shifter
    // ****************************************
    assign halt       = idle_stop_ff & idle_ff;
    assign push_acc   = push_valid_i & ready_ff;
    assign full_flag  = (count_ff >= fifo_cap(polynomial_length_i));
    assign empty_flag = (count_ff == CNT_ZERO);

    // Next values of the data path; a cleared enable overrides all of them except the bit order flag
    always_comb begin
        nxt_wr_ptr  = wr_ptr_ff;
        nxt_rd_ptr  = rd_ptr_ff;
        nxt_state   = state_ff;
        nxt_shreg   = shreg_ff;
        nxt_bits    = bits_ff;
        nxt_lsb     = lsb_ff;
        nxt_bit     = bit_ff;
        nxt_bit_vld = 1'b0;
        nxt_done    = 1'b0;
        pop         = 1'b0;
        done_evt    = 1'b0;
        case (state_ff)
            CRCECS_IDLE: begin
                // Only a set start bit lets a word leave the FIFO
                if (go_ff && !halt && !empty_flag) begin
                    pop       = 1'b1;
                    nxt_rd_ptr = rd_ptr_ff + PTR_ONE;
                    nxt_lsb   = dir_ff;
                    nxt_state = CRCECS_SHIFT;
                    if (short_word(polynomial_length_i)) begin
                        nxt_bits = BITS_SHORT;
                        // In top-bit-first order short words are moved up so the top bit is bit 15
                        nxt_shreg = dir_ff ? mem_ff[rd_ptr_ff]
                                           : (mem_ff[rd_ptr_ff] << SHORT_SHIFT);
                    end else begin
                        nxt_bits  = BITS_LONG;
                        nxt_shreg = mem_ff[rd_ptr_ff];
                    end
                end
            end
            CRCECS_SHIFT: begin
                if (!halt) begin
                    nxt_bit_vld = 1'b1;
                    if (lsb_ff) begin
                        nxt_bit   = shreg_ff[0];
                        nxt_shreg = shreg_ff >> 1;
                    end else begin
                        nxt_bit   = shreg_ff[DATA_W-1];
                        nxt_shreg = shreg_ff << 1;
                    end
                    nxt_bits = bits_ff - CNT_ONE;
                    if (bits_ff == CNT_ONE) begin
                        nxt_state = CRCECS_IDLE;
                        // Result is ready only when no word waits behind this one
                        if (empty_flag && !push_acc) begin
                            done_evt = 1'b1;
                            nxt_done = 1'b1;
                        end
                    end
                end
            end
            default: begin
                nxt_state = CRCECS_IDLE;
            end
        endcase
        if (push_acc) begin
            nxt_wr_ptr = wr_ptr_ff + PTR_ONE;
        end
        nxt_count = count_ff + {4'h0, push_acc} - {4'h0, pop};
        empty_evt = pop && !push_acc && (count_ff == CNT_ONE);
        if (!en_ff) begin
            nxt_wr_ptr  = '0;
            nxt_rd_ptr  = '0;
            nxt_count   = CNT_ZERO;
            nxt_state   = CRCECS_IDLE;
            nxt_shreg   = '0;
            nxt_bits    = CNT_ZERO;
            nxt_bit     = 1'b0;
            nxt_bit_vld = 1'b0;
            nxt_done    = 1'b0;
            done_evt    = 1'b0;
            empty_evt   = 1'b0;
        end
        // Ready is registered, so it is judged on the count of the next cycle
        nxt_ready = nxt_en && (nxt_count < fifo_cap(polynomial_length_i));
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wr_ptr_ff  <= '0;
            rd_ptr_ff  <= '0;
            count_ff   <= CNT_ZERO;
            ready_ff   <= 1'b0;
            state_ff   <= CRCECS_IDLE;
            shreg_ff   <= '0;
            bits_ff    <= CNT_ZERO;
            lsb_ff     <= 1'b0;
            bit_ff     <= 1'b0;
            bit_vld_ff <= 1'b0;
            done_ff    <= 1'b0;
        end else begin
            wr_ptr_ff  <= nxt_wr_ptr;
            rd_ptr_ff  <= nxt_rd_ptr;
            count_ff   <= nxt_count;
            ready_ff   <= nxt_ready;
            state_ff   <= nxt_state;
            shreg_ff   <= nxt_shreg;
            bits_ff    <= nxt_bits;
            lsb_ff     <= nxt_lsb;
            bit_ff     <= nxt_bit;
            bit_vld_ff <= nxt_bit_vld;
            done_ff    <= nxt_done;
        end
    end

    // Storage has no reset; the pointers and the word count decide what is valid
    always_ff @(posedge clk_i) begin
        if (push_acc) begin
            mem_ff[wr_ptr_ff] <= push_data_i;
        end
    end

    // ****************************************
    // Registers and interrupt
    // ****************************************
    logic crc_evt;
    logic wr_ctrl;

    assign crc_evt = isel_ff ? empty_evt : done_evt;
    assign wr_ctrl = reg_wr_i && (reg_addr_i == ADDR_CTRL);

    // Software writes, hardware clear of start, read data and sticky status
    always_comb begin
        nxt_en        = en_ff;
        nxt_idle_stop = idle_stop_ff;
        nxt_isel      = isel_ff;
        nxt_dir       = dir_ff;
        nxt_mask      = mask_ff;
        // Start drops by itself once the result is ready
        nxt_go        = done_evt ? 1'b0 : go_ff;
        if (wr_ctrl) begin
            // Bit 14 has no storage, so a write there is lost
            nxt_en        = reg_wdata_i[BIT_EN];
            nxt_idle_stop = reg_wdata_i[BIT_IDLE];
            nxt_isel      = reg_wdata_i[BIT_ISEL];
            nxt_go        = reg_wdata_i[BIT_GO];
            nxt_dir       = reg_wdata_i[BIT_DIR];
        end
        if (reg_wr_i && (reg_addr_i == ADDR_INT_MASK)) begin
            nxt_mask = reg_wdata_i[INT_W-1:0];
        end
        // Read clears status, but an event in the same cycle survives
        nxt_stat = stat_ff;
        if (reg_rd_i && (reg_addr_i == ADDR_INT_STAT)) begin
            nxt_stat = '0;
        end
        nxt_stat[INT_CRC] = nxt_stat[INT_CRC] | crc_evt;
        nxt_irq   = |(nxt_stat & nxt_mask);
        nxt_clear = !nxt_en;
        nxt_rdata = '0;
        if (reg_rd_i) begin
            case (reg_addr_i)
                ADDR_CTRL: begin
                    nxt_rdata[BIT_EN]           = en_ff;
                    nxt_rdata[BIT_RSVD]         = 1'b0;
                    nxt_rdata[BIT_IDLE]         = idle_stop_ff;
                    nxt_rdata[CNT_HI:CNT_LO]    = count_ff;
                    nxt_rdata[BIT_FULL]         = full_flag;
                    nxt_rdata[BIT_EMPTY]        = empty_flag;
                    nxt_rdata[BIT_ISEL]         = isel_ff;
                    nxt_rdata[BIT_GO]           = go_ff;
                    nxt_rdata[BIT_DIR]          = dir_ff;
                end
                ADDR_INT_STAT: begin
                    nxt_rdata[INT_W-1:0] = stat_ff;
                end
                ADDR_INT_MASK: begin
                    nxt_rdata[INT_W-1:0] = mask_ff;
                end
                default: begin
                    nxt_rdata = '0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            en_ff        <= 1'b0;
            idle_stop_ff <= 1'b0;
            isel_ff      <= 1'b0;
            go_ff        <= 1'b0;
            dir_ff       <= 1'b0;
            stat_ff      <= '0;
            mask_ff      <= '0;
            rdata_ff     <= '0;
            irq_ff       <= 1'b0;
            clear_ff     <= 1'b1;
        end else begin
            en_ff        <= nxt_en;
            idle_stop_ff <= nxt_idle_stop;
            isel_ff      <= nxt_isel;
            go_ff        <= nxt_go;
            dir_ff       <= nxt_dir;
            stat_ff      <= nxt_stat;
            mask_ff      <= nxt_mask;
            rdata_ff     <= nxt_rdata;
            irq_ff       <= nxt_irq;
            clear_ff     <= nxt_clear;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign reg_rdata_o       = rdata_ff;
    assign push_ready_o      = ready_ff;
    assign crc_bit_o         = bit_ff;
    assign crc_bit_valid_o   = bit_vld_ff;
    assign result_ready_o    = done_ff;
    assign crc_state_clear_o = clear_ff;
    assign irq_o             = irq_ff;

endmodule

/* dv/crcecs_properties.sv */
// Port-level assertions for the CRC engine control and status block
`timescale 1ns/100ps
module crcecs_properties
    import crcecs_pkg::*;
#(
    parameter int unsigned DEPTH = 16
) (
    // Clock and reset
    input wire logic              clk_i,
    input wire logic              sys_rst_i,
    // Register port and context
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire logic              reg_rd_i,
    input wire logic [DATA_W-1:0] reg_rdata_o,
    input wire logic [POLYNOMIAL_LENGTH_W-1:0] polynomial_length_i,
    // Stream and interrupt
    input wire logic              push_ready_o,
    input wire logic              crc_bit_valid_o,
    input wire logic              result_ready_o,
    input wire logic              crc_state_clear_o,
    input wire logic              irq_o
);
    // ****************************************
    // Properties
    // ****************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    // Count field of the answer; only meaningful after a control read
    logic [CNT_W-1:0] cnt;
    assign cnt = reg_rdata_o[CNT_HI:CNT_LO];

    sequence ctl_ans;
        $past(reg_rd_i && reg_addr_i == ADDR_CTRL);
    endsequence

    a_rd_quiet: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 16'h0000)
        else $error("read data not zero outside an answer");
    a_unmapped_zero: assert property ($past(reg_rd_i && reg_addr_i == 2'h3) |-> reg_rdata_o == 16'h0000)
        else $error("unmapped index read not zero");
    a_rsvd_bit_zero: assert property ($past(reg_rd_i) |-> !reg_rdata_o[BIT_RSVD])
        else $error("unimplemented bit read as one");
    a_empty_flag: assert property (ctl_ans |-> reg_rdata_o[BIT_EMPTY] == (cnt == 5'h00))
        else $error("empty flag disagrees with count");
    a_full_flag: assert property (ctl_ans |-> reg_rdata_o[BIT_FULL] ==
        (cnt == ($past(polynomial_length_i) > POLYNOMIAL_LENGTH_SHORT_MAX ? DEPTH / 2 : DEPTH)))
        else $error("full flag disagrees with count");
    a_count_range: assert property (ctl_ans |->
        cnt <= ($past(polynomial_length_i) > POLYNOMIAL_LENGTH_SHORT_MAX ? DEPTH / 2 : DEPTH))
        else $error("word count above capacity");
    // The pulse rides with the last bit; a halt just before that bit must not matter
    a_result_pulse: assert property (result_ready_o |-> crc_bit_valid_o ##1 !result_ready_o)
        else $error("result pulse not beside last bit or longer than one cycle");
    a_clear_quiet: assert property (crc_state_clear_o && $past(crc_state_clear_o) |->
        !push_ready_o && !crc_bit_valid_o && !result_ready_o)
        else $error("activity while module disabled");

    // Main scenarios reached
    c_result: cover property (result_ready_o);
    c_irq: cover property (irq_o);
    c_full: cover property (ctl_ans ##0 reg_rdata_o[BIT_FULL]);
endmodule

bind crcecs_top crcecs_properties #(.DEPTH(DEPTH)) u_props (.clk_i, .sys_rst_i, .reg_addr_i, .reg_rd_i,
    .reg_rdata_o, .polynomial_length_i, .push_ready_o, .crc_bit_valid_o, .result_ready_o,
    .crc_state_clear_o, .irq_o);

/* dv/testbench.sv */
// Self-checking bench for the CRC engine control and status block
`timescale 1ns/100ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin errors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module testbench
    import crcecs_pkg::*;
;
    // ****************************************
    // Stimulus, design and collectors
    // ****************************************
    logic              clk_i = 1'h0, sys_rst_i = 1'h1;
    logic [ADDR_W-1:0] reg_addr_i = 2'h0;
    logic [DATA_W-1:0] reg_wdata_i = 16'h0000, push_data_i = 16'h0000, reg_rdata_o;
    logic              reg_wr_i = 1'h0, reg_rd_i = 1'h0, push_valid_i = 1'h0, idle_mode_i = 1'h0;
    logic [POLYNOMIAL_LENGTH_W-1:0] polynomial_length_i = 4'h7;
    logic              push_ready_o, crc_bit_o, crc_bit_valid_o, result_ready_o, crc_state_clear_o, irq_o;
    logic [15:0]       msb_acc = 16'h0000, lsb_acc = 16'h0000;
    logic              irq_first = 1'h0, done = 1'h0;
    int                errors = 0, cmp_count = 0, nbits = 0, got = 0;

    crcecs_top #(.DEPTH(16)) uut (.clk_i, .sys_rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
        .reg_rdata_o, .polynomial_length_i, .idle_mode_i, .push_valid_i, .push_data_i, .push_ready_o,
        .crc_bit_o, .crc_bit_valid_o, .result_ready_o, .crc_state_clear_o, .irq_o);

    // 10 MHz clock
    always #50 clk_i = ~clk_i;

    // Gather bits in both orders; irq at the first bit tells pop event from done event,
    // since a done event raises irq together with the last bit
    // A control write starts a run, so it clears the tallies; this process alone owns them
    always @(posedge clk_i) begin
        if (crc_bit_valid_o === 1'h1) begin
            msb_acc <= {msb_acc[14:0], crc_bit_o};
            lsb_acc <= {crc_bit_o, lsb_acc[15:1]};
            nbits   <= nbits + 1;
            if (nbits == 0) irq_first <= irq_o;
        end
        if (result_ready_o === 1'h1) done <= 1'h1;
        if (reg_wr_i === 1'h1 && reg_addr_i == ADDR_CTRL) begin
            nbits <= 0;
            done  <= 1'h0;
        end
    end

    // Bus cycles; an idle cycle after each keeps strobes from being driven twice in one step
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_wr_i    <= 1'h1;
        @(posedge clk_i);
        reg_wr_i <= 1'h0;
        @(posedge clk_i);
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        reg_addr_i <= a;
        reg_rd_i   <= 1'h1;
        @(posedge clk_i);
        reg_rd_i <= 1'h0;
        @(negedge clk_i);
        `CHK(reg_rdata_o, e)
        @(posedge clk_i);
    endtask

    // Offer words until want are taken or 40 cycles pass (full FIFO refuses)
    task automatic fill(input logic [DATA_W-1:0] d, input int want);
        got = 0;
        push_data_i  <= d;
        push_valid_i <= 1'h1;
        for (int i = 0; i < 40 && got < want; i++) begin
            @(posedge clk_i);
            if (push_ready_o === 1'h1) got++;
        end
        push_valid_i <= 1'h0;
        @(posedge clk_i);
    endtask

    // Start the shifter and wait, bounded, for the result pulse
    task automatic run(input logic [DATA_W-1:0] ctrl, input logic halt);
        wr(ADDR_CTRL, ctrl);
        if (halt) begin
            repeat (30) @(posedge clk_i);
            `CHK(nbits, 0)
            idle_mode_i <= 1'h0;
        end
        for (int i = 0; i < 300 && !done; i++) @(posedge clk_i);
        if (!done) begin
            errors++;
            report_and_stop();
        end
        repeat (3) @(posedge clk_i);
    endtask

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (3) @(posedge clk_i);
        sys_rst_i <= 1'h0;
        @(posedge clk_i);
        rd(ADDR_CTRL, 16'h0040);
        wr(ADDR_CTRL, 16'h7FFF);
        rd(ADDR_CTRL, 16'h2078);
        rd(2'h3, 16'h0000);
        $display("Test ended: field access");
        wr(ADDR_CTRL, 16'h8000);
        fill(16'h0011, 99);
        `CHK(got, 16)
        rd(ADDR_CTRL, 16'h9080);
        `CHK(nbits, 0)
        `CHK(crc_state_clear_o, 1'h0)
        wr(ADDR_CTRL, 16'h0000);
        rd(ADDR_CTRL, 16'h0040);
        `CHK(crc_state_clear_o, 1'h1)
        polynomial_length_i <= 4'h8;
        wr(ADDR_CTRL, 16'h8000);
        fill(16'h1234, 99);
        `CHK(got, 8)
        rd(ADDR_CTRL, 16'h8880);
        wr(ADDR_CTRL, 16'h0000);
        polynomial_length_i <= 4'h7;
        $display("Test ended: fifo depth");
        wr(ADDR_INT_MASK, 16'h0001);
        wr(ADDR_CTRL, 16'h8000);
        fill(16'h00A5, 1);
        rd(ADDR_CTRL, 16'h8100);
        run(16'h8010, 1'h0);
        `CHK(msb_acc[7:0], 8'hA5)
        `CHK(nbits, 8)
        `CHK(irq_first, 1'h0)
        `CHK(irq_o, 1'h1)
        rd(ADDR_INT_STAT, 16'h0001);
        rd(ADDR_CTRL, 16'h8040);
        `CHK(irq_o, 1'h0)
        $display("Test ended: msb first");
        wr(ADDR_INT_MASK, 16'h0000);
        fill(16'h0031, 1);
        idle_mode_i <= 1'h1;
        run(16'h8018, 1'h0);
        `CHK(lsb_acc[15:8], 8'h31)
        `CHK(irq_o, 1'h0)
        rd(ADDR_INT_STAT, 16'h0001);
        $display("Test ended: lsb first in idle");
        wr(ADDR_INT_MASK, 16'h0001);
        fill(16'h00C3, 1);
        run(16'hA030, 1'h1);
        `CHK(msb_acc[7:0], 8'hC3)
        `CHK(irq_first, 1'h1)
        $display("Test ended: idle halt");
        // Long polynomial: whole 16-bit word, top bit first, no pre-shift
        polynomial_length_i <= 4'h8;
        fill(16'h5A3C, 1);
        run(16'h8010, 1'h0);
        `CHK(msb_acc, 16'h5A3C)
        `CHK(nbits, 16)
        polynomial_length_i <= 4'h7;
        $display("Test ended: long word msb first");
        report_and_stop();
    end
endmodule
